// >>> sim/csts_src_model.sv
module csts_src_model
   import csts_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire csts_pkg::csts_sources_t fire,
   output csts_pkg::csts_sources_t      sources
);
   timeunit 1ns;
   timeprecision 100ps;
   // Sources move only on the clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sources <= '0;
      end else begin
         sources <= fire;
      end
   end
endmodule

// >>> sim/csts_top_asserts.sv
module csts_top_asserts
   import csts_pkg::*;
#(
   parameter int CHANNEL = 1
) (
   input wire logic                     pclk,
   input wire logic                     presetn,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pready,
   input wire logic [31:0]              prdata,
   input wire logic                     pslverr,
   input wire logic                     partner_cascade_enable,
   input wire logic                     cascade_active,
   input wire logic                     sync_pulse,
   input wire logic                     trigger_status,
   input wire logic [csts_pkg::SEL_W-1:0] sync_source_select
);
   timeunit 1ns;
   timeprecision 100ps;
   wire none = !(sync_source_select inside
      {[5'h01:5'h04], [5'h0A:5'h13], [5'h18:5'h1C]});
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   pulse_single_a: assert property (sync_pulse |=> !sync_pulse)
      else $error("pulse too long");
   pulse_trig_a: assert property (sync_pulse |-> trigger_status)
      else $error("status not set");
   cascade_pair_a: assert property
      (cascade_active |-> $past(partner_cascade_enable))
      else $error("cascade without partner");
   no_source_a: assert property (none [*4] |-> !sync_pulse)
      else $error("pulse from no source");
   reset_sel_a: assert property
      ($rose(presetn) |-> sync_source_select == SEL_RESET && !trigger_status)
      else $error("bad reset select");
   apb_answer_a: assert property (psel && !penable |=> pready)
      else $error("no ready");
   apb_err_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   idle_data_a: assert property (!pready |-> prdata == 32'h0)
      else $error("data while idle");
   cover property (sync_pulse);
   cover property (cascade_active);
   cover property (pslverr);
endmodule

bind csts_top csts_top_asserts #(.CHANNEL(CHANNEL)) csts_top_asserts_i (
   .pclk, .presetn, .psel, .penable, .pready, .prdata, .pslverr,
   .partner_cascade_enable, .cascade_active, .sync_pulse,
   .trigger_status, .sync_source_select);

// >>> sim/tb.sv
module tb
   import csts_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic          partner, cas_o, cas_act, pulse, trig, err;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd, rnd;
   logic [3:0]    pstrb;
   logic [4:0]    sel_o;
   csts_sources_t fire, src;
   int            errors, compares, hits;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

   csts_src_model csts_src_model_i (.pclk, .presetn, .fire, .sources(src));
   csts_top #(.CHANNEL(1)) csts_top_i (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
      .sources(src), .partner_cascade_enable(partner),
      .cascade_enable(cas_o), .cascade_active(cas_act),
      .sync_pulse(pulse), .trigger_status(trig), .sync_source_select(sel_o));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic csts_sources_t exp_src(input logic [4:0] c);
      csts_sources_t s;
      s = '0;
      if (c >= 5'h01 && c <= 5'h04) s.compare[c - 5'h01] = 1'b1;
      if (c == 5'h0A) s.trig_gen[0] = 1'b1;
      if (c >= 5'h0B && c <= 5'h0F) s.timer[c - 5'h0B] = 1'b1;
      if (c >= 5'h10 && c <= 5'h13) s.capture[c - 5'h10] = 1'b1;
      if (c >= 5'h18 && c <= 5'h1A) s.comparator[c - 5'h18] = 1'b1;
      s.converter = (c == 5'h1B);
      s.charge_time = (c == 5'h1C);
      return s;
   endfunction

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] st);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic count(input int k);
      hits = 0;
      repeat (k) begin
         @(posedge pclk);
         if (pulse === 1'b1) hits++;
      end
   endtask

   task automatic ev(input logic [4:0] c);
      csts_sources_t e;
      logic h;
      e = exp_src(c);
      h = (e != '0);
      // Trigger mode set for comparator and converter codes
      apb(1'b1, OFF_CTRL_TWO, {rnd[15:0], 8'h00,
          c inside {[5'h18:5'h1B]}, 2'b00, c}, 4'h3);
      apb(1'b1, OFF_EVENT_CNT, 32'h0, 4'hF);
      apb(1'b0, OFF_STATUS, 32'h0, 4'hF);
      `CHK(rd[1], h)
      fire <= ~e;
      count(6);
      `CHK(hits, 0)
      fire <= '1;
      count(6);
      `CHK(hits, int'(h))
      apb(1'b0, OFF_STATUS, 32'h0, 4'hF);
      `CHK(rd[2], h)
      fire <= '0;
      count(3);
      apb(1'b0, OFF_CTRL_TWO, 32'h0, 4'hF);
      `CHK(rd[6:0], {h, 1'b0, c})
      `CHK(trig, h)
      `CHK(sel_o, c)
      apb(1'b0, OFF_EVENT_CNT, 32'h0, 4'hF);
      `CHK(rd, {31'h0, h})
   endtask

   task automatic finish_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #500000;
      errors++;
      finish_test;
   end

   initial begin
      {presetn, psel, penable, pwrite, partner} = 5'h00;
      {paddr, pwdata, pstrb, fire} = '0;
      {errors, compares} = 0;
      rnd = 32'hD8C3;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFF_CTRL_TWO, 32'h0, 4'hF);
      `CHK(rd, 32'h0000_000D)
      `CHK(sel_o, SEL_RESET)
      apb(1'b0, 12'h00C, 32'h0, 4'hF);
      `CHK({err, rd}, {1'b1, 32'h0})
      $display("test reset done");
      apb(1'b1, OFF_CTRL_TWO, 32'h40, 4'hF);
      apb(1'b1, OFF_CTRL_TWO, 32'h105, 4'h2);
      apb(1'b0, OFF_CTRL_TWO, 32'h0, 4'hF);
      `CHK(rd, 32'h0000_0140)
      apb(1'b0, OFF_STATUS, 32'h0, 4'hF);
      `CHK(rd[0], 1'b0)
      partner <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b0, OFF_STATUS, 32'h0, 4'hF);
      `CHK(rd[0], 1'b1)
      `CHK(cas_o, 1'b1)
      `CHK(cas_act, 1'b1)
      partner <= 1'b0;
      $display("test cascade done");
      // Own capture code skipped on channel one
      for (int c = 0; c < 32; c++) if (c != 16) ev(5'(c));
      $display("test codes done");
      repeat (20) begin
         rnd = lfsr(rnd);
         if (rnd[4:0] != 5'h10) ev(rnd[4:0]);
      end
      $display("test random done");
      finish_test;
   end
endmodule

// >>> verilog/csts_pkg.sv
package csts_pkg;

   localparam int SEL_W = 5;
   localparam int REG_W = 16;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 12;

   localparam logic [SEL_W-1:0] SEL_NONE_LO = 5'h00;
   localparam logic [SEL_W-1:0] SEL_CMP_FIRST = 5'h01;
   localparam logic [SEL_W-1:0] SEL_CMP_LAST = 5'h04;
   localparam logic [SEL_W-1:0] SEL_TRIG_GEN = 5'h0A;
   localparam logic [SEL_W-1:0] SEL_TMR_FIRST = 5'h0B;
   localparam logic [SEL_W-1:0] SEL_TMR_LAST = 5'h0F;
   localparam logic [SEL_W-1:0] SEL_CAP_FIRST = 5'h10;
   localparam logic [SEL_W-1:0] SEL_CAP_LAST = 5'h13;
   localparam logic [SEL_W-1:0] SEL_CMPR_FIRST = 5'h18;
   localparam logic [SEL_W-1:0] SEL_CMPR_LAST = 5'h1A;
   localparam logic [SEL_W-1:0] SEL_CONVERTER = 5'h1B;
   localparam logic [SEL_W-1:0] SEL_CHARGE_TIME = 5'h1C;
   localparam logic [SEL_W-1:0] SEL_NONE_HI = 5'h1F;
   localparam logic [SEL_W-1:0] SEL_RESET = 5'h0D;

   localparam logic [ADDR_W-1:0] OFF_CTRL_TWO = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_EVENT_CNT = 12'h008;

   localparam int BIT_SEL_LSB = 0;
   localparam int BIT_TRIG_STATUS = 6;
   localparam int BIT_TRIG_MODE = 7;
   localparam int BIT_CASCADE = 8;

   localparam int BIT_ST_CASCADE = 0;
   localparam int BIT_ST_CONNECTED = 1;
   localparam int BIT_ST_LEVEL = 2;

   localparam int TRIG_GEN_BASE = 8;

   typedef struct packed {
      logic [4:0] timer;
      logic [3:0] compare;
      logic [3:0] capture;
      logic [2:0] comparator;
      logic       converter;
      logic       charge_time;
      logic [3:0] trig_gen;
   } csts_sources_t;

   typedef struct packed {
      logic             cascade_enable;
      logic             trig_mode;
      logic             trig_status;
      logic [SEL_W-1:0] select;
   } csts_ctrl_t;

endpackage

// >>> verilog/csts_source_mux.sv
module csts_source_mux
   import csts_pkg::*;
#(
   parameter int CHANNEL = 1
) (
   input  wire csts_pkg::csts_sources_t src,
   input  wire logic [csts_pkg::SEL_W-1:0] select,
   output logic connected,
   output logic level
);

   function automatic logic in_range(input logic [SEL_W-1:0] s,
                                     input logic [SEL_W-1:0] lo,
                                     input logic [SEL_W-1:0] hi);
      in_range = (s >= lo) && (s <= hi);
   endfunction

   localparam int TG_IDX = CHANNEL - 1;

   wire sel_cmp  = in_range(select, SEL_CMP_FIRST, SEL_CMP_LAST);
   wire sel_tmr  = in_range(select, SEL_TMR_FIRST, SEL_TMR_LAST);
   wire sel_cap  = in_range(select, SEL_CAP_FIRST, SEL_CAP_LAST);
   wire sel_cmpr = in_range(select, SEL_CMPR_FIRST, SEL_CMPR_LAST);
   wire sel_tg   = (select == SEL_TRIG_GEN);
   wire sel_adc  = (select == SEL_CONVERTER);
   wire sel_ctu  = (select == SEL_CHARGE_TIME);

   wire [SEL_W-1:0] off_cmp  = select - SEL_CMP_FIRST;
   wire [SEL_W-1:0] off_tmr  = select - SEL_TMR_FIRST;
   wire [SEL_W-1:0] off_cap  = select - SEL_CAP_FIRST;
   wire [SEL_W-1:0] off_cmpr = select - SEL_CMPR_FIRST;

   wire lvl_cmp  = src.compare[off_cmp[1:0]];
   wire lvl_tmr  = src.timer[off_tmr[2:0]];
   wire lvl_cap  = src.capture[off_cap[1:0]];
   wire lvl_cmpr = src.comparator[off_cmpr[1:0]];
   wire lvl_tg   = src.trig_gen[TG_IDX];

   assign connected = sel_cmp | sel_tmr | sel_cap | sel_cmpr
                    | sel_tg | sel_adc | sel_ctu;

   assign level = (sel_cmp  & lvl_cmp)
                | (sel_tmr  & lvl_tmr)
                | (sel_cap  & lvl_cap)
                | (sel_cmpr & lvl_cmpr)
                | (sel_tg   & lvl_tg)
                | (sel_adc  & src.converter)
                | (sel_ctu  & src.charge_time);

endmodule

// >>> verilog/csts_top.sv
// Register access over APB and the register offsets were chosen for this implementation.
module csts_top
   import csts_pkg::*;
#(
   parameter int CHANNEL = 1
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [11:0]               paddr,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic                           pready,
   output logic [31:0]                    prdata,
   output logic                           pslverr,
   input  wire csts_pkg::csts_sources_t   sources,
   input  wire logic                      partner_cascade_enable,
   output logic                           cascade_enable,
   output logic                           cascade_active,
   output logic                           sync_pulse,
   output logic                           trigger_status,
   output logic [csts_pkg::SEL_W-1:0]     sync_source_select
);

   import csts_pkg::*;

   csts_ctrl_t       ctrl;
   logic             src_sampled;
   logic             src_prev;
   logic             src_connected_q;
   logic [CNT_W-1:0] event_count;
   logic             apb_resp;
   logic [31:0]      rdata_q;
   logic             slverr_q;

   wire             mux_connected;
   wire             mux_level;

   csts_source_mux #(
      .CHANNEL   (CHANNEL)
   ) u_mux (
      .src       (sources),
      .select    (ctrl.select),
      .connected (mux_connected),
      .level     (mux_level)
   );

   // Bus phase decode
   wire setup_phase  = psel & ~penable & ~apb_resp;
   wire access_done  = psel & penable & apb_resp;
   wire hit_ctrl     = (paddr == OFF_CTRL_TWO);
   wire hit_status   = (paddr == OFF_STATUS);
   wire hit_count    = (paddr == OFF_EVENT_CNT);
   wire hit_any      = hit_ctrl | hit_status | hit_count;
   wire wr_done      = access_done & pwrite & hit_any;
   wire wr_ctrl      = wr_done & hit_ctrl;
   wire wr_count     = wr_done & hit_count;
   wire lane0        = pstrb[0];
   wire lane1        = pstrb[1];

   // Rising edge of the selected, sampled source
   wire src_event    = src_sampled & ~src_prev;

   // Control register two and status register views
   wire [REG_W-1:0] ctrl_word = {
      {(REG_W-BIT_CASCADE-1){1'b0}},
      ctrl.cascade_enable,
      ctrl.trig_mode,
      ctrl.trig_status,
      1'b0,
      ctrl.select
   };

   wire [REG_W-1:0] status_word = {
      {(REG_W-BIT_ST_LEVEL-1){1'b0}},
      src_sampled,
      src_connected_q,
      cascade_active
   };

   wire [31:0] read_mux =
        hit_ctrl   ? {16'h0000, ctrl_word}   :
        hit_status ? {16'h0000, status_word} :
        hit_count  ? {16'h0000, event_count} :
                     32'h0000_0000;

   // Software write values, masked by byte lanes
   wire [SEL_W-1:0] wr_select = lane0 ?
        pwdata[BIT_SEL_LSB +: SEL_W] : ctrl.select;
   wire wr_trig_status = lane0 ?
        pwdata[BIT_TRIG_STATUS] : ctrl.trig_status;
   wire wr_trig_mode = lane0 ?
        pwdata[BIT_TRIG_MODE] : ctrl.trig_mode;
   wire wr_cascade = lane1 ?
        pwdata[BIT_CASCADE] : ctrl.cascade_enable;

   // Hardware set wins over a software clear
   wire next_trig_status = src_event |
        (wr_ctrl ? wr_trig_status : ctrl.trig_status);

   wire [CNT_W-1:0] next_count =
        wr_count ? (src_event ? 16'h0001 : 16'h0000) :
        (src_event ? event_count + 16'h0001 : event_count);

   // Bus answer: one access cycle, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_resp <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end else begin
         apb_resp <= setup_phase;
         if (setup_phase) begin
            rdata_q  <= pwrite ? 32'h0000_0000 : read_mux;
            slverr_q <= ~hit_any;
         end else if (access_done) begin
            rdata_q  <= 32'h0000_0000;
            slverr_q <= 1'b0;
         end
      end
   end

   // Control register two, one process owns every field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl.select         <= SEL_RESET;
         ctrl.trig_mode      <= 1'b0;
         ctrl.cascade_enable <= 1'b0;
         ctrl.trig_status    <= 1'b0;
      end else begin
         ctrl.trig_status    <= next_trig_status;
         if (wr_ctrl) begin
            ctrl.select         <= wr_select;
            ctrl.trig_mode      <= wr_trig_mode;
            ctrl.cascade_enable <= wr_cascade;
         end
      end
   end

   // Source sampling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_sampled     <= 1'b0;
         src_prev        <= 1'b0;
         src_connected_q <= 1'b0;
      end else begin
         src_sampled     <= mux_connected & mux_level;
         src_prev        <= src_sampled;
         src_connected_q <= mux_connected;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_count <= 16'h0000;
      end else begin
         event_count <= next_count;
      end
   end

   // Channel facing outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_pulse         <= 1'b0;
         trigger_status     <= 1'b0;
         cascade_enable     <= 1'b0;
         cascade_active     <= 1'b0;
         sync_source_select <= SEL_RESET;
      end else begin
         sync_pulse         <= src_event;
         trigger_status     <= next_trig_status;
         cascade_enable     <= ctrl.cascade_enable;
         cascade_active     <= ctrl.cascade_enable
                             & partner_cascade_enable;
         sync_source_select <= ctrl.select;
      end
   end

   assign pready  = apb_resp;
   assign prdata  = rdata_q;
   assign pslverr = slverr_q;

endmodule
